/* File: prisc_device.sv */
// bridge device end: interrupt steering, reset, arbiter strap, parity
`timescale 1ns/1ps

// Functional notes
// - nmi is level detected, highest priority
// - secondary devices hold interrupt until cleared
// - steer secondary irq to primary or core
// - each core irq input has fixed level
// - primary irq open drain, held while pending
// - primary reset floats outputs except grant0, which is driven deasserted, and asserts secondary reset
// - host releases primary reset cleanly
// - secondary reset derived from primary reset
// - sample arbiter strap at reset release
// - grant0 pin: grant or own request
// - request0 pin: request or own grant
// - grants 1-5, requests 1-4, request5 on strap
// - parity even over address data and command
// - parity errors and system errors reported
module prisc_device (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic        clk_en,
	// pins
	prisc_if.device          pins,
	// steering and core side
	input  wire logic [3:0]  steer_to_core,
	input  wire logic        own_request,
	input  wire logic [4:0]  arb_grant_1_5,
	input  wire logic        arb_grant_0,
	input  wire logic        special_cycle,
	input  wire logic        fault,
	output logic             nmi_pending,
	output logic [7:0]       core_irq_level,
	output logic [2:0]       core_irq_top,
	output logic             arbiter_enabled,
	output logic [5:0]       dev_requests,
	output logic             own_grant,
	output logic             parity_error_seen,
	output logic             in_reset
);

	// ==========================================================
	// synchronisers
	logic [9:0] sync1_reg;
	logic [9:0] sync2_reg;
	logic       rst_s1_reg;
	logic       rst_s2_reg;
	logic [9:0] raw_async;

	assign raw_async = {pins.core_ext_irq_high_n, pins.sec_int_n,
		pins.nmi_n, pins.sec_request5_arbiter_strap};

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sync1_reg <= 10'h3ff;
			sync2_reg <= 10'h3ff;
		end else if (clk_en) begin
			sync1_reg <= raw_async;
			sync2_reg <= sync1_reg;
		end
	end

	// reset release sync; assertion acts at once, release is clocked
	always_ff @(posedge core_clk or negedge pins.pri_rst_n) begin
		if (!pins.pri_rst_n) begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end else if (clk_en) begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end

	// ==========================================================
	// reset sequencer and strap capture
	prisc_pkg::prisc_state_t state_reg;
	prisc_pkg::prisc_state_t state_next;
	logic arb_en_reg;
	logic arb_en_next;

	always_comb begin
		state_next  = state_reg;
		arb_en_next = arb_en_reg;
		case (state_reg)
			prisc_pkg::PRISC_ST_RESET: begin
				// strap frozen as the release reaches rst_s2
				// the pin already carries request 5 one clock later
				if (!rst_s2_reg)
					arb_en_next = (sync2_reg[0] == prisc_pkg::ARB_EN_VAL);
				else
					state_next = prisc_pkg::PRISC_ST_SAMPLE;
			end
			prisc_pkg::PRISC_ST_SAMPLE: begin
				state_next  = prisc_pkg::PRISC_ST_RUN;
			end
			prisc_pkg::PRISC_ST_RUN: begin
				state_next = prisc_pkg::PRISC_ST_RUN;
			end
			default: state_next = prisc_pkg::PRISC_ST_RESET;
		endcase
		if (!rst_s2_reg)
			state_next = prisc_pkg::PRISC_ST_RESET;
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_reg  <= prisc_pkg::PRISC_ST_RESET;
			arb_en_reg <= prisc_pkg::ARB_EN_RST;
		end else if (clk_en) begin
			state_reg  <= state_next;
			arb_en_reg <= arb_en_next;
		end
	end

	logic running;
	logic live;
	assign running         = (state_reg == prisc_pkg::PRISC_ST_RUN);
	// pins go quiet as soon as primary reset falls, not one clock later
	assign live            = running & pins.pri_rst_n;
	assign in_reset        = !running;
	assign arbiter_enabled = arb_en_reg;

	// secondary reset asserts with primary reset at once, releases two clocks after it
	assign pins.sec_rst_n = pins.pri_rst_n & rst_s2_reg;

	// ==========================================================
	// interrupts
	logic [7:0] lvl_reg;
	logic [7:0] lvl_next;
	logic [3:0] pint_reg;
	logic [3:0] pint_next;
	logic       nmi_reg;
	logic       nmi_next;
	logic [2:0] top_reg;
	logic [2:0] top_next;

	always_comb begin
		nmi_next = !sync2_reg[1];
		// lines are levels, steered per bit
		lvl_next[3:0] = ~sync2_reg[5:2] & steer_to_core;
		pint_next     = ~sync2_reg[5:2] & ~steer_to_core;
		// dedicated: bit n is level n+4
		lvl_next[7:4] = ~sync2_reg[9:6];
		top_next = 3'h0;
		for (int i = 0; i < 8; i++) begin
			if (lvl_next[i])
				top_next = i[2:0];
		end
		if (!running) begin
			lvl_next  = 8'h00;
			pint_next = 4'h0;
			nmi_next  = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			lvl_reg  <= 8'h00;
			pint_reg <= 4'h0;
			nmi_reg  <= 1'b0;
			top_reg  <= 3'h0;
		end else if (clk_en) begin
			lvl_reg  <= lvl_next;
			pint_reg <= pint_next;
			nmi_reg  <= nmi_next;
			top_reg  <= top_next;
		end
	end

	// nmi masks the level report while it is active
	assign nmi_pending    = nmi_reg;
	assign core_irq_level = nmi_reg ? 8'h00 : lvl_reg;
	assign core_irq_top   = top_reg;

	// open drain: drive low only while pending, gated by reset
	assign pins.pri_int_o  = 4'h0;
	assign pins.pri_int_oe = pint_reg & {4{pins.pri_rst_n}};

	// ==========================================================
	// arbitration pins
	// grant0 pin meaning follows the strap
	assign pins.sec_grant0_or_own_request_n = !live ?
		prisc_pkg::DEASSERT_N :
		(arb_en_reg ? !arb_grant_0 : !own_request);
	// grants 1-5 float while in reset
	assign pins.sec_grants_n  = live ? ~arb_grant_1_5 :
		prisc_pkg::GNTS_N_OFF;
	assign pins.sec_grants_oe = live;
	// request inputs, request5 shares the strap pin
	assign dev_requests = {!sync2_reg[0], ~pins.sec_requests_n,
		arb_en_reg & !pins.sec_request0_or_own_grant_n};
	assign own_grant = !arb_en_reg & !pins.sec_request0_or_own_grant_n;

	// ==========================================================
	// parity and error reporting
	logic perr_reg;
	logic perr_next;
	logic par_calc;

	assign par_calc = ^{pins.sec_ad, pins.sec_cbe_n};

	always_comb begin
		// only judged while an agent drives the bus
		perr_next = running && pins.sec_parity_oe &&
			(par_calc != pins.sec_parity);
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			perr_reg <= 1'b0;
		else if (clk_en)
			perr_reg <= perr_next;
	end

	assign parity_error_seen = perr_reg;
	// data parity on perr, special cycle and faults on serr
	assign pins.sec_parity_error_n  = !(perr_reg & !special_cycle);
	assign pins.sec_parity_error_oe = live;
	assign pins.sec_system_error_o  = prisc_pkg::ASSERT_N;
	assign pins.sec_system_error_oe = live &
		((perr_reg & special_cycle) | fault);
	assign pins.pri_system_error_o  = prisc_pkg::ASSERT_N;
	assign pins.pri_system_error_oe = live & fault;

endmodule

/* File: prisc_pkg.sv */
// shared constants for the pci reset, interrupt, arbiter and strap logic
package prisc_pkg;

	// ==========================================================
	// widths
	localparam int SEC_INT_W   = 4;
	localparam int XINT_HI_W   = 4;
	localparam int GNT_W       = 5;
	localparam int REQ_W       = 4;
	localparam int AD_W        = 32;
	localparam int CBE_W       = 4;

	// ==========================================================
	// reset values and strap encodings
	localparam logic ARB_EN_VAL     = 1'b1;
	localparam logic ARB_EN_RST     = 1'b0;
	localparam logic DEASSERT_N     = 1'b1;
	localparam logic ASSERT_N       = 1'b0;
	localparam logic STEER_CORE     = 1'b1;
	localparam logic [3:0] ALL_N_OFF   = 4'hf;
	localparam logic [4:0] GNTS_N_OFF  = 5'h1f;

	// ==========================================================
	// reset sequencer states, one-hot
	typedef enum logic [2:0] {
		PRISC_ST_RESET = 3'b001,
		PRISC_ST_SAMPLE = 3'b010,
		PRISC_ST_RUN   = 3'b100
	} prisc_state_t;

endpackage

/* File: prisc_if.sv */
// pin-level link between the bridge device end and the system end
`timescale 1ns/1ps
interface prisc_if;
	// primary reset from the host
	logic        pri_rst_n;
	// secondary interrupts from secondary devices
	logic [3:0]  sec_int_n;
	// primary open-drain interrupt lines: drive low while enabled
	logic [3:0]  pri_int_o;
	logic [3:0]  pri_int_oe;
	// non-maskable and high external interrupts
	logic        nmi_n;
	logic [3:0]  core_ext_irq_high_n;
	// secondary reset and arbitration pins
	logic        sec_rst_n;
	logic        sec_grant0_or_own_request_n;
	logic        sec_request0_or_own_grant_n;
	logic [4:0]  sec_grants_n;
	logic        sec_grants_oe;
	logic [3:0]  sec_requests_n;
	logic        sec_request5_arbiter_strap;
	// system error lines, open drain
	logic        pri_system_error_o;
	logic        pri_system_error_oe;
	logic        sec_system_error_o;
	logic        sec_system_error_oe;
	logic        sec_system_error_in;
	// parity error lines and parity bits
	logic        sec_parity_error_n;
	logic        sec_parity_error_oe;
	logic        sec_parity;
	logic        sec_parity_oe;
	logic [31:0] sec_ad;
	logic [3:0]  sec_cbe_n;

	modport device (
		input  pri_rst_n, sec_int_n, nmi_n, core_ext_irq_high_n,
		input  sec_request0_or_own_grant_n, sec_requests_n,
		input  sec_request5_arbiter_strap, sec_system_error_in,
		input  sec_ad, sec_cbe_n, sec_parity, sec_parity_oe,
		output pri_int_o, pri_int_oe, sec_rst_n,
		output sec_grant0_or_own_request_n, sec_grants_n, sec_grants_oe,
		output pri_system_error_o, pri_system_error_oe,
		output sec_system_error_o, sec_system_error_oe,
		output sec_parity_error_n, sec_parity_error_oe
	);

	modport system (
		output pri_rst_n, sec_int_n, nmi_n, core_ext_irq_high_n,
		output sec_request0_or_own_grant_n, sec_requests_n,
		output sec_request5_arbiter_strap, sec_system_error_in,
		output sec_ad, sec_cbe_n, sec_parity, sec_parity_oe,
		input  pri_int_o, pri_int_oe, sec_rst_n,
		input  sec_grant0_or_own_request_n, sec_grants_n, sec_grants_oe,
		input  pri_system_error_o, pri_system_error_oe,
		input  sec_system_error_o, sec_system_error_oe,
		input  sec_parity_error_n, sec_parity_error_oe
	);
endinterface

/* File: prisc_system.sv */
// system end: host reset, secondary devices, parity generation
`timescale 1ns/1ps
module prisc_system (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic        clk_en,
	// pins
	prisc_if.system          pins,
	// user side
	input  wire logic        host_reset,
	input  wire logic        strap_arb_en,
	input  wire logic [3:0]  dev_irq_raise,
	input  wire logic [3:0]  drv_irq_clear,
	input  wire logic        nmi_req,
	input  wire logic [3:0]  high_irq,
	input  wire logic [5:0]  dev_req,
	input  wire logic [31:0] ad_data,
	input  wire logic [3:0]  cbe_n,
	input  wire logic        drive_bus,
	input  wire logic        parity_flip,
	output logic [3:0]       pri_int_seen,
	output logic             sec_rst_seen_n
);

	// ==========================================================
	// held interrupt requests
	logic [3:0] irq_reg;
	logic [3:0] irq_next;
	logic       rst_reg;
	logic       rst_next;

	always_comb begin
		// hold until driver clears; raise wins over clear
		irq_next = (irq_reg & ~drv_irq_clear) | dev_irq_raise;
		rst_next = !host_reset;
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			irq_reg <= 4'h0;
			rst_reg <= 1'b0;
		end else if (clk_en) begin
			irq_reg <= irq_next;
			rst_reg <= rst_next;
		end
	end

	assign pins.pri_rst_n = rst_reg;
	assign pins.sec_int_n = ~irq_reg;
	assign pins.nmi_n     = !nmi_req;
	assign pins.core_ext_irq_high_n = ~high_irq;
	// strap drives the shared pin during reset, then device 5 request
	assign pins.sec_request5_arbiter_strap = rst_reg ? !dev_req[5] :
		strap_arb_en;
	assign pins.sec_requests_n = ~dev_req[4:1];
	assign pins.sec_request0_or_own_grant_n = !dev_req[0];
	assign pins.sec_system_error_in = prisc_pkg::DEASSERT_N;

	// ==========================================================
	// bus data and parity
	assign pins.sec_ad    = ad_data;
	assign pins.sec_cbe_n = cbe_n;
	// even parity
	// flip lets a scenario present a bad parity bit on purpose
	assign pins.sec_parity    = ^{ad_data, cbe_n} ^ parity_flip;
	assign pins.sec_parity_oe = drive_bus;

	// observe open-drain lines as pulled low
	assign pri_int_seen   = pins.pri_int_oe;
	assign sec_rst_seen_n = pins.sec_rst_n;

endmodule

/* File: prisc_checker.sv */
// pin checks between the device and system ends
`timescale 1ns/1ps
module prisc_checker (
	// clock and reset
	input wire logic        core_clk,
	input wire logic        rstn,
	// reset and interrupt pins
	input wire logic        pri_rst_n,
	input wire logic [3:0]  sec_int_n,
	input wire logic [3:0]  pri_int_oe,
	input wire logic        sec_rst_n,
	input wire logic        sec_grants_oe,
	// error and parity pins
	input wire logic        pri_system_error_oe,
	input wire logic        sec_system_error_oe,
	input wire logic        sec_parity_error_n,
	input wire logic        sec_parity_error_oe,
	input wire logic        sec_parity,
	input wire logic [31:0] sec_ad,
	input wire logic [3:0]  sec_cbe_n
);
	// ==========
	// sequences
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
	wire bad_par = ^{sec_ad, sec_cbe_n, sec_parity};
	sequence rst_rel;
		$rose(pri_rst_n);
	endsequence
	sequence sec_up;
		##[1:5] sec_rst_n;
	endsequence
	// ==========
	// assertions
	a_sec_rst_follow: assert property (!pri_rst_n |-> !sec_rst_n)
		else $error("secondary reset not asserted");
	a_grants_float: assert property (!pri_rst_n |-> !sec_grants_oe)
		else $error("grants driven in reset");
	a_serr_float: assert property (!pri_rst_n |->
		!pri_system_error_oe && !sec_system_error_oe)
		else $error("system error driven in reset");
	a_irq_float: assert property (!pri_rst_n |-> pri_int_oe == 4'h0)
		else $error("primary irq driven in reset");
	a_perr_float: assert property (!pri_rst_n |-> !sec_parity_error_oe)
		else $error("parity error driven in reset");
	a_sec_rst_rel: assert property (rst_rel |-> sec_up)
		else $error("secondary reset not released");
	// two sync flops plus one register before the pin
	a_irq_cause: assert property (
		(pri_int_oe & $past(sec_int_n, 3)) == 4'h0)
		else $error("primary irq without secondary irq");
	a_perr_cause: assert property (
		sec_parity_error_oe && !sec_parity_error_n |->
		$past(bad_par) || $past(bad_par, 2))
		else $error("parity error without odd parity");
endmodule

/* File: prisc_tb.sv */
// self-checking bench joining the device and system ends
`timescale 1ns/1ps
module prisc_tb;
	typedef struct packed {
		logic [3:0] steer, raise, high, pri;
		logic [7:0] lvl;
		logic [2:0] top;
	} prisc_row_t;
	logic        core_clk = 1'b0, rstn = 1'b0, host_reset = 1'b1;
	logic        strap = 1'b1, nmi_req = 1'b0, own_req = 1'b0;
	logic        agnt0 = 1'b0, spec = 1'b0, fault = 1'b0, drv = 1'b0;
	logic        flip = 1'b0;
	logic [3:0]  steer = 4'h0, raise = 4'h0, clr = 4'h0, high = 4'h0;
	logic [3:0]  cbe = 4'h0, pri_seen;
	logic [4:0]  agnt = 5'h00;
	logic [5:0]  dev_req = 6'h00, dreq;
	logic [31:0] ad = 32'h0;
	logic [7:0]  lvl;
	logic [2:0]  top;
	logic        srst_n, nmi_p, arb_en, own_gnt, perr, in_rst;
	int          error_cnt = 0, num_checks = 0, cyc = 0;
	prisc_row_t  rows [5] = '{
		'{4'h0, 4'hf, 4'h0, 4'hf, 8'h00, 3'h0},
		'{4'hf, 4'hf, 4'h0, 4'h0, 8'h0f, 3'h3},
		'{4'h5, 4'ha, 4'h9, 4'ha, 8'h90, 3'h7},
		'{4'h3, 4'h5, 4'h2, 4'h4, 8'h21, 3'h5},
		'{4'hc, 4'h2, 4'h0, 4'h2, 8'h00, 3'h0}};

	prisc_if pins_if ();
	prisc_device prisc_device_i (.core_clk, .rstn, .clk_en(1'b1),
		.pins(pins_if.device), .steer_to_core(steer),
		.own_request(own_req), .arb_grant_1_5(agnt), .arb_grant_0(agnt0),
		.special_cycle(spec), .fault, .nmi_pending(nmi_p),
		.core_irq_level(lvl), .core_irq_top(top), .arbiter_enabled(arb_en),
		.dev_requests(dreq), .own_grant(own_gnt),
		.parity_error_seen(perr), .in_reset(in_rst));
	prisc_system prisc_system_i (.core_clk, .rstn, .clk_en(1'b1),
		.pins(pins_if.system), .host_reset, .strap_arb_en(strap),
		.dev_irq_raise(raise), .drv_irq_clear(clr), .nmi_req,
		.high_irq(high), .dev_req, .ad_data(ad), .cbe_n(cbe),
		.drive_bus(drv), .parity_flip(flip), .pri_int_seen(pri_seen),
		.sec_rst_seen_n(srst_n));
	prisc_checker prisc_checker_i (.core_clk, .rstn,
		.pri_rst_n(pins_if.pri_rst_n), .sec_int_n(pins_if.sec_int_n),
		.pri_int_oe(pins_if.pri_int_oe), .sec_rst_n(pins_if.sec_rst_n),
		.sec_grants_oe(pins_if.sec_grants_oe),
		.pri_system_error_oe(pins_if.pri_system_error_oe),
		.sec_system_error_oe(pins_if.sec_system_error_oe),
		.sec_parity_error_n(pins_if.sec_parity_error_n),
		.sec_parity_error_oe(pins_if.sec_parity_error_oe),
		.sec_parity(pins_if.sec_parity), .sec_ad(pins_if.sec_ad),
		.sec_cbe_n(pins_if.sec_cbe_n));

	// ==========
	// clock, timeout and helpers
	always #12.5 core_clk = ~core_clk;
	// a hang never reaches the closing report otherwise
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			close_out();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#2;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ==========
	// main sequence
	initial begin
		tick(6);
		rstn = 1'b1;
		tick(2);
		host_reset = 1'b0;
		tick(10);
		chk("arb_en", 8'(1), 8'(arb_en));
		chk("in_reset", 8'(0), 8'(in_rst));
		foreach (rows[i]) begin
			steer = rows[i].steer;
			high = rows[i].high;
			raise = rows[i].raise;
			tick(1);
			raise = 4'h0;
			tick(12);
			chk("pri_int", 8'(rows[i].pri), 8'(pri_seen));
			chk("level", rows[i].lvl, lvl);
			if (rows[i].lvl != 8'h00)
				chk("top", 8'(rows[i].top), 8'(top));
			clr = 4'hf;
			high = 4'h0;
			tick(1);
			clr = 4'h0;
			tick(6);
			chk("pri_clr", 8'(0), 8'(pri_seen));
		end
		// nmi masks the level report while it is held
		steer = 4'hf;
		high = 4'hf;
		raise = 4'hf;
		nmi_req = 1'b1;
		tick(1);
		raise = 4'h0;
		tick(6);
		chk("nmi", 8'(1), 8'(nmi_p));
		chk("nmi_lvl", 8'h00, lvl);
		nmi_req = 1'b0;
		high = 4'h0;
		clr = 4'hf;
		tick(1);
		clr = 4'h0;
		agnt0 = 1'b1;
		agnt = 5'h15;
		dev_req = 6'h3f;
		tick(6);
		chk("gnt0", 8'(0), 8'(pins_if.sec_grant0_or_own_request_n));
		chk("gnts", 8'h0a, 8'(pins_if.sec_grants_n));
		chk("reqs", 8'h3f, 8'(dreq));
		agnt0 = 1'b0;
		agnt = 5'h00;
		dev_req = 6'h00;
		drv = 1'b1;
		ad = 32'h8000_0001;
		cbe = 4'h1;
		fault = 1'b1;
		tick(4);
		chk("par", 8'h01, 8'(pins_if.sec_parity));
		chk("perr", 8'(0), 8'(perr));
		chk("serr", 8'(1), 8'(pins_if.pri_system_error_oe
			| pins_if.sec_system_error_oe));
		fault = 1'b0;
		flip = 1'b1;
		tick(2);
		chk("perr_on", 8'(1), 8'(perr));
		chk("perr_pin", 8'(0), 8'(pins_if.sec_parity_error_n));
		spec = 1'b1;
		tick(1);
		chk("serr_spec", 8'(1), 8'(pins_if.sec_system_error_oe));
		chk("perr_spec", 8'(1), 8'(pins_if.sec_parity_error_n));
		flip = 1'b0;
		spec = 1'b0;
		drv = 1'b0;
		strap = 1'b0;
		host_reset = 1'b1;
		tick(3);
		chk("srst", 8'(0), 8'(srst_n));
		chk("gnt_oe", 8'(0), 8'(pins_if.sec_grants_oe));
		chk("in_rst", 8'(1), 8'(in_rst));
		host_reset = 1'b0;
		tick(10);
		chk("arb_off", 8'(0), 8'(arb_en));
		chk("srst_up", 8'(1), 8'(srst_n));
		own_req = 1'b1;
		dev_req = 6'h01;
		tick(6);
		chk("own_req", 8'(0), 8'(pins_if.sec_grant0_or_own_request_n));
		chk("own_gnt", 8'(1), 8'(own_gnt));
		own_req = 1'b0;
		dev_req = 6'h00;
		tick(6);
		chk("own_gnt0", 8'(0), 8'(own_gnt));
		close_out();
	end
endmodule
